/* File: pwmf_pkg.sv */
// Package with register map, field positions and codes of the PWM fault block.
package pwmf_pkg;
  localparam int CW = 16;
  localparam int NF = 4;
  localparam int NP = 2;
  localparam int EW = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_ON_A = 8'h08;
  localparam logic [7:0] OFS_OFF_A = 8'h0C;
  localparam logic [7:0] OFS_ON_B = 8'h10;
  localparam logic [7:0] OFS_OFF_B = 8'h14;
  localparam logic [7:0] OFS_FCTL = 8'h18;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h1C;
  localparam logic [7:0] OFS_FMAP = 8'h20;
  localparam logic [7:0] OFS_CCTL = 8'h24;
  localparam logic [7:0] OFS_CV0 = 8'h28;
  localparam logic [7:0] OFS_CV1 = 8'h2C;
  localparam logic [7:0] OFS_CSTS = 8'h30;
  // Control register fields.
  localparam int B_RUN = 0;
  localparam int B_FORCE = 1;
  localparam int B_POL = 4;
  localparam int B_OUTEN = 8;
  localparam int B_MASK = 12;
  localparam int B_TRIG = 16;
  // Fault control, status and map fields.
  localparam int B_LVL = 0;
  localparam int B_AUTO = 4;
  localparam int B_SAFE = 8;
  localparam int B_FULL = 4;
  localparam int B_FACT = 8;
  localparam int B_DIS = 12;
  localparam int B_FST = 8;
  // Capture control fields.
  localparam int B_EN0 = 0;
  localparam int B_EN1 = 1;
  localparam int B_ONE = 2;
  localparam int B_SEL = 3;
  localparam int B_EDG0 = 4;
  localparam int B_EDG1 = 6;
  localparam int B_ECMP = 8;
  localparam int B_ARM = 16;
  localparam int B_IEN = 17;
  // Output fault state codes.
  localparam logic [1:0] FS_LOW = 2'h0;
  localparam logic [1:0] FS_HIGH = 2'h1;
  // Capture edge select codes.
  localparam logic [1:0] ED_FALL = 2'h1;
  localparam logic [1:0] ED_RISE = 2'h2;
  localparam logic [1:0] ED_BOTH = 2'h3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0300;
  localparam logic [CW-1:0] PERIOD_RST = 16'h00FF;
endpackage : pwmf_pkg

/* File: pwmf_cap_if.sv */
// Interface carrying configuration and results between top and capture unit.
`timescale 1ns/10ps
interface pwmf_cap_if;
  import pwmf_pkg::*;
  logic [31:0] cfg;
  logic arm;
  logic [CW-1:0] cnt;
  logic [CW-1:0] cv0;
  logic [CW-1:0] cv1;
  logic [1:0] hit;
  modport top (output cfg, arm, cnt, input cv0, cv1, hit);
  modport cap (input cfg, arm, cnt, output cv0, cv1, hit);
endinterface : pwmf_cap_if

/* File: pwmf_cap.sv */
// Enhanced dual-circuit input capture with edge-count prescaler.
`timescale 1ns/10ps
module pwmf_cap (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Capture pin.
  input wire logic pin_i,
  pwmf_cap_if.cap cif
);
  import pwmf_pkg::*;
  logic [EW-1:0] ecnt_q, ecnt_d;
  logic pin_q, pin_d, src_q, src_d, pls;
  logic [1:0] arm_q, arm_d, hit_d;
  logic [CW-1:0] cv0_d, cv1_d;
  logic [CW-1:0] cv0_q, cv1_q;
  logic [1:0] hit_q;
  logic src;

  function automatic logic edge_hit(input logic [1:0] s, input logic p, input logic c);
    edge_hit = ((s == ED_RISE || s == ED_BOTH) && !p && c) ||
               ((s == ED_FALL || s == ED_BOTH) && p && !c);
  endfunction : edge_hit

  // Prescaler counts both edges, pulses on match; mux picks pin or pulse.
  always_comb
  begin
    pin_d = pin_i;
    ecnt_d = ecnt_q;
    pls = 1'b0;
    if (pin_i != pin_q)
    begin
      ecnt_d = ecnt_q + 8'h01;
      if (ecnt_d == cif.cfg[B_ECMP +: EW])
      begin
        pls = 1'b1;
        ecnt_d = 8'h00;
      end
    end
    src = cif.cfg[B_SEL] ? pls : pin_i;
    src_d = src;
  end

  // Arming: ping-pong when both enabled, one sequence in one-shot mode.
  always_comb
  begin
    arm_d = arm_q;
    hit_d = 2'h0;
    cv0_d = cv0_q;
    cv1_d = cv1_q;
    if (arm_q[0] && edge_hit(cif.cfg[B_EDG0 +: 2], src_q, src))
    begin
      hit_d[0] = 1'b1;
      cv0_d = cif.cnt;
      arm_d[0] = 1'b0;
      if (cif.cfg[B_EN1])
        arm_d[1] = 1'b1;
      else if (!cif.cfg[B_ONE])
        arm_d[0] = 1'b1;
    end
    if (arm_q[1] && edge_hit(cif.cfg[B_EDG1 +: 2], src_q, src))
    begin
      hit_d[1] = 1'b1;
      cv1_d = cif.cnt;
      arm_d[1] = 1'b0;
      if (!cif.cfg[B_ONE])
      begin
        if (cif.cfg[B_EN0])
          arm_d[0] = 1'b1;
        else
          arm_d[1] = 1'b1;
      end
    end
    if (cif.arm)
      arm_d = cif.cfg[B_EN0] ? 2'h1 : {cif.cfg[B_EN1], 1'b0};
    arm_d = arm_d & cif.cfg[B_EN0 +: 2];
  end

  // Registers of the capture unit.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ecnt_q <= 8'h00;
      pin_q <= 1'b0;
      src_q <= 1'b0;
      arm_q <= 2'h0;
      hit_q <= 2'h0;
      cv0_q <= 16'h0000;
      cv1_q <= 16'h0000;
    end
    else
    begin
      ecnt_q <= ecnt_d;
      pin_q <= pin_d;
      src_q <= src_d;
      arm_q <= arm_d;
      hit_q <= hit_d;
      cv0_q <= cv0_d;
      cv1_q <= cv1_d;
    end
  end
  assign cif.cv0 = cv0_q;
  assign cif.cv1 = cv1_q;
  assign cif.hit = hit_q;

  a_cap_one_shot: assert property (@(posedge mclk_i) disable iff (reset_i)
    hit_q[1] && cif.cfg[B_ONE] && !$past(cif.arm) |-> arm_q == 2'h0)
    else $error("one-shot capture rearmed");
  a_prescale_wrap: assert property (@(posedge mclk_i) disable iff (reset_i)
    pls |=> ecnt_q == 8'h00)
    else $error("edge counter not reset on match");
endmodule : pwmf_cap

/* File: pwmf_top.sv */
// PWM fault protection, output control, capture and trigger block with APB.
`timescale 1ns/10ps
module pwmf_top (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Fault inputs and capture pin.
  input wire logic [pwmf_pkg::NF-1:0] fault_i,
  input wire logic aux_channel_pin_i,
  // PWM pins, output enable active low.
  output logic [pwmf_pkg::NP-1:0] pwm_o,
  output logic [pwmf_pkg::NP-1:0] pwm_oe_n_o,
  // Triggers and capture requests.
  output logic [1:0] trig_o,
  output logic [1:0] cap_irq_o
);
  import pwmf_pkg::*;
  pwmf_cap_if cif ();

  logic [31:0] ctrl_q, ctrl_d;
  logic [CW-1:0] per_q, per_d;
  logic [CW-1:0] on_a_q, on_a_d, off_a_q, off_a_d;
  logic [CW-1:0] on_b_q, on_b_d, off_b_q, off_b_d;
  logic [15:0] fctl_q, fctl_d;
  logic [NF-1:0] ffull_q, ffull_d;
  logic [NF-1:0] fflag_q, fflag_d;
  logic [NF-1:0] fdis_q, fdis_d;
  logic [15:0] fmap_q, fmap_d;
  logic [31:0] cctl_q, cctl_d;
  logic [1:0] cflag_q, cflag_d;
  logic [NP-1:0] mask_q, mask_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d, arm_q, arm_d;
  logic [NP-1:0] pin_q, pin_d, oen_q, oen_d;
  logic [1:0] trig_q, trig_d, irq_q, irq_d;
  logic acc, wr, full, half, known;
  logic [NF-1:0] fact, rel;
  logic [NP-1:0] raw, pdis;

  function automatic logic in_win(input logic [CW-1:0] c, input logic [CW-1:0] a,
                                  input logic [CW-1:0] b);
    in_win = (c >= a) && (c < b);
  endfunction : in_win

  // APB handshake: access phase lasts two cycles, pready is registered.
  always_comb
  begin
    acc = psel_i && penable_i && rdy_q;
    wr = acc && pwrite_i;
    rdy_d = psel_i && penable_i && !rdy_q;
    known = 1'b1;
    rdata_d = 32'h0000_0000;
    if (paddr_i == OFS_CTRL)
      rdata_d = ctrl_q;
    else if (paddr_i == OFS_PERIOD)
      rdata_d = {16'h0000, per_q};
    else if (paddr_i == OFS_ON_A)
      rdata_d = {16'h0000, on_a_q};
    else if (paddr_i == OFS_OFF_A)
      rdata_d = {16'h0000, off_a_q};
    else if (paddr_i == OFS_ON_B)
      rdata_d = {16'h0000, on_b_q};
    else if (paddr_i == OFS_OFF_B)
      rdata_d = {16'h0000, off_b_q};
    else if (paddr_i == OFS_FCTL)
      rdata_d = {16'h0000, fctl_q};
    else if (paddr_i == OFS_FAULT_STATUS)
      rdata_d = {18'h00000, pdis, fact, ffull_q, fflag_q};
    else if (paddr_i == OFS_FMAP)
      rdata_d = {16'h0000, fmap_q};
    else if (paddr_i == OFS_CCTL)
      rdata_d = cctl_q;
    else if (paddr_i == OFS_CV0)
      rdata_d = {16'h0000, cif.cv0};
    else if (paddr_i == OFS_CV1)
      rdata_d = {16'h0000, cif.cv1};
    else if (paddr_i == OFS_CSTS)
      rdata_d = {30'h0000_0000, cflag_q};
    else
      known = 1'b0;
    err_d = rdy_d && !known;
    if (!rdy_d || pwrite_i || !known)
      rdata_d = 32'h0000_0000;
  end

  // Configuration registers written in the completing APB cycle.
  always_comb
  begin
    ctrl_d = ctrl_q;
    per_d = per_q;
    on_a_d = on_a_q;
    off_a_d = off_a_q;
    on_b_d = on_b_q;
    off_b_d = off_b_q;
    fctl_d = fctl_q;
    ffull_d = ffull_q;
    fmap_d = fmap_q;
    cctl_d = cctl_q;
    arm_d = 1'b0;
    if (wr && paddr_i == OFS_CTRL)
      ctrl_d = pwdata_i;
    if (wr && paddr_i == OFS_PERIOD)
      per_d = pwdata_i[CW-1:0];
    if (wr && paddr_i == OFS_ON_A)
      on_a_d = pwdata_i[CW-1:0];
    if (wr && paddr_i == OFS_OFF_A)
      off_a_d = pwdata_i[CW-1:0];
    if (wr && paddr_i == OFS_ON_B)
      on_b_d = pwdata_i[CW-1:0];
    if (wr && paddr_i == OFS_OFF_B)
      off_b_d = pwdata_i[CW-1:0];
    if (wr && paddr_i == OFS_FCTL)
      fctl_d = pwdata_i[15:0];
    if (wr && paddr_i == OFS_FAULT_STATUS)
      ffull_d = pwdata_i[B_FULL +: NF];
    if (wr && paddr_i == OFS_FMAP)
      fmap_d = pwdata_i[15:0];
    if (wr && paddr_i == OFS_CCTL)
    begin
      cctl_d = pwdata_i;
      cctl_d[B_ARM] = 1'b0;
      arm_d = pwdata_i[B_ARM];
    end
    // Force bit is a strobe, never stored.
    ctrl_d[B_FORCE] = 1'b0;
  end

  // Period counter with full-cycle and half-cycle boundaries.
  always_comb
  begin
    cnt_d = cnt_q;
    if (ctrl_q[B_RUN])
      cnt_d = (cnt_q >= per_q) ? 16'h0000 : cnt_q + 16'h0001;
    full = ctrl_q[B_RUN] && cnt_q == 16'h0000;
    half = ctrl_q[B_RUN] && cnt_q == (per_q >> 1);
  end

  // Fault detection, sticky flags and pin disable per fault input.
  always_comb
  begin
    fact = fault_i ^ fctl_q[B_LVL +: NF];
    fflag_d = fflag_q;
    if (wr && paddr_i == OFS_FAULT_STATUS)
      fflag_d = fflag_q & ~pwdata_i[NF-1:0];
    fflag_d = fflag_d | fact;
    for (int i = 0; i < NF; i++)
    begin
      rel[i] = full || (half && !ffull_q[i]);
      if (fctl_q[B_AUTO + i])
        rel[i] = rel[i] && !fact[i];
      else if (fctl_q[B_SAFE + i])
        rel[i] = rel[i] && !fflag_q[i] && !fact[i];
      else
        rel[i] = rel[i] && !fflag_q[i];
      fdis_d[i] = fact[i] || (fdis_q[i] && !rel[i]);
    end
    pdis = '0;
    for (int p = 0; p < NP; p++)
      for (int i = 0; i < NF; i++)
        pdis[p] = pdis[p] | (fdis_q[i] & fmap_q[i * NP + p]);
  end

  // Pin stage: mask on force, polarity, fault state, output enable.
  always_comb
  begin
    mask_d = mask_q;
    if (wr && paddr_i == OFS_CTRL && pwdata_i[B_FORCE])
      mask_d = pwdata_i[B_MASK +: NP];
    raw[0] = in_win(cnt_q, on_a_q, off_a_q);
    raw[1] = in_win(cnt_q, on_b_q, off_b_q);
    for (int p = 0; p < NP; p++)
    begin
      pin_d[p] = (raw[p] & !mask_q[p]) ^ ctrl_q[B_POL + p];
      oen_d[p] = 1'b0;
      if (pdis[p])
      begin
        pin_d[p] = fmap_q[B_FST + 2 * p +: 2] == FS_HIGH;
        oen_d[p] = fmap_q[B_FST + 2 * p +: 2] > FS_HIGH;
      end
      if (!ctrl_q[B_OUTEN + p])
      begin
        pin_d[p] = 1'b0;
        oen_d[p] = 1'b1;
      end
    end
    trig_d[0] = ctrl_q[B_TRIG] && ctrl_q[B_RUN] && cnt_q == on_b_q;
    trig_d[1] = ctrl_q[B_TRIG + 1] && ctrl_q[B_RUN] && cnt_q == off_b_q;
  end

  // Capture flags and requests; a new hit wins over a clear.
  always_comb
  begin
    cflag_d = cflag_q;
    if (wr && paddr_i == OFS_CSTS)
      cflag_d = cflag_q & ~pwdata_i[1:0];
    cflag_d = cflag_d | cif.hit;
    irq_d = cflag_d & cctl_q[B_IEN +: 2];
  end

  assign cif.cfg = cctl_q;
  assign cif.arm = arm_q;
  assign cif.cnt = cnt_q;

  pwmf_cap u_cap (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i(aux_channel_pin_i),
    .cif(cif)
  );

  // All state registers of the top level.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= CTRL_RST;
      per_q <= PERIOD_RST;
      on_a_q <= 16'h0000;
      off_a_q <= 16'h0000;
      on_b_q <= 16'h0000;
      off_b_q <= 16'h0000;
      fctl_q <= 16'h0000;
      ffull_q <= '0;
      fflag_q <= '0;
      fdis_q <= '0;
      fmap_q <= 16'h0000;
      cctl_q <= 32'h0000_0000;
      cflag_q <= 2'h0;
      mask_q <= '0;
      cnt_q <= 16'h0000;
      rdata_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      arm_q <= 1'b0;
      pin_q <= '0;
      oen_q <= '1;
      trig_q <= 2'h0;
      irq_q <= 2'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      on_a_q <= on_a_d;
      off_a_q <= off_a_d;
      on_b_q <= on_b_d;
      off_b_q <= off_b_d;
      fctl_q <= fctl_d;
      ffull_q <= ffull_d;
      fflag_q <= fflag_d;
      fdis_q <= fdis_d;
      fmap_q <= fmap_d;
      cctl_q <= cctl_d;
      cflag_q <= cflag_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      arm_q <= arm_d;
      pin_q <= pin_d;
      oen_q <= oen_d;
      trig_q <= trig_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_o = rdata_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
  assign pwm_o = pin_q;
  assign pwm_oe_n_o = oen_q;
  assign trig_o = trig_q;
  assign cap_irq_o = irq_q;

  a_flag_sticky: assert property (@(posedge mclk_i) disable iff (reset_i)
    fflag_q[0] && !(wr && paddr_i == OFS_FAULT_STATUS) |=> fflag_q[0])
    else $error("fault flag dropped without clear");
  a_fault_sets: assert property (@(posedge mclk_i) disable iff (reset_i)
    fact[0] |=> fdis_q[0] && fflag_q[0])
    else $error("active fault not latched");
  a_auto_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    fctl_q[B_AUTO] && fdis_q[0] && !full && !half |=> fdis_q[0])
    else $error("auto clear away from boundary");
  a_full_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    ffull_q[0] && fdis_q[0] && !full |=> fdis_q[0])
    else $error("release outside full cycle");
  a_manual_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    !fctl_q[B_AUTO] && fdis_q[0] && fflag_q[0] |=> fdis_q[0])
    else $error("manual release with flag set");
  a_safe_level: assert property (@(posedge mclk_i) disable iff (reset_i)
    !fctl_q[B_AUTO] && fctl_q[B_SAFE] && fdis_q[0] && fact[0] |=> fdis_q[0])
    else $error("safe mode release while fault high");
  a_outen_tri: assert property (@(posedge mclk_i) disable iff (reset_i)
    !ctrl_q[B_OUTEN] |=> pwm_oe_n_o[0])
    else $error("disabled output driven");
  a_apb_wait: assert property (@(posedge mclk_i) disable iff (reset_i)
    psel_i && penable_i && !rdy_q |=> pready_o)
    else $error("apb answer late");
endmodule : pwmf_top

/* File: pwmf_stage.sv */
// Model of the power stage: fault sources and gate drivers with a weak pull-up.
`timescale 1ns/10ps
module pwmf_stage (
  // Clock.
  input wire logic mclk_i,
  // Commands from the bench.
  input wire logic [3:0] fault_cmd_i,
  input wire logic aux_cmd_i,
  // Device pins.
  input wire logic [1:0] pwm_i,
  input wire logic [1:0] pwm_oe_n_i,
  output logic [3:0] fault_o = 4'h0,
  output logic aux_o = 1'b0,
  output logic [1:0] gate_o
);
  // Sources settle just after an edge, so the device never samples a changing level.
  always @(posedge mclk_i)
  begin
    fault_o <= fault_cmd_i;
    aux_o <= aux_cmd_i;
  end
  // A released pin floats up through the pull-up, so it reads high whatever value it drove last.
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      gate_o[p] = pwm_oe_n_i[p] ? 1'b1 : pwm_i[p];
    end
  end
endmodule : pwmf_stage

/* File: test_pwmf_top.sv */
// Self-checking testbench of the PWM fault, capture and trigger block.
`timescale 1ns/10ps
module test_pwmf_top;
  import pwmf_pkg::*;
  localparam int PER = 15;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic s;} pwmf_row_t;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] cv;
  logic pready;
  logic pslverr;
  logic err;
  logic [3:0] fault_cmd = 4'h0;
  logic aux_cmd = 1'b0;
  logic [3:0] fault_w;
  logic aux_w;
  logic [1:0] pwm;
  logic [1:0] oe_n;
  logic [1:0] gate;
  logic [1:0] trig;
  logic [1:0] irq;
  int num_errors = 0;
  int total_checks = 0;
  int n0;
  int n1;
  logic [31:0] fctl [3] = '{32'h0000_0010, 32'h0000_0000, 32'h0000_0100};
  logic hold [3] = '{1'b0, 1'b1, 1'b1};
  // Setup writes keep init <= edges <= period and change frequency through the period only.
  // Fractional delay is never enabled, so its edge spacing and pairing limits hold trivially.
  pwmf_row_t rows [11] = '{
    '{1'b0, OFS_CTRL, 32'h0, CTRL_RST, 1'b0},
    '{1'b0, OFS_PERIOD, 32'h0, 32'h0000_00FF, 1'b0},
    '{1'b1, OFS_PERIOD, 32'h0000_000F, 32'h0, 1'b0},
    '{1'b0, OFS_PERIOD, 32'h0, 32'h0000_000F, 1'b0},
    '{1'b1, OFS_ON_A, 32'h0000_0002, 32'h0, 1'b0},
    '{1'b1, OFS_OFF_A, 32'h0000_0009, 32'h0, 1'b0},
    '{1'b1, OFS_ON_B, 32'h0000_0003, 32'h0, 1'b0},
    '{1'b1, OFS_OFF_B, 32'h0000_0005, 32'h0, 1'b0},
    '{1'b1, OFS_FMAP, 32'h0000_0101, 32'h0, 1'b0},
    '{1'b0, OFS_FMAP, 32'h0, 32'h0000_0101, 1'b0},
    '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1}};
  always #20 mclk_i = ~mclk_i;
  pwmf_top u_pwmf_top (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fault_i(fault_w),
    .aux_channel_pin_i(aux_w), .pwm_o(pwm), .pwm_oe_n_o(oe_n), .trig_o(trig),
    .cap_irq_o(irq));
  pwmf_stage u_pwmf_stage (.mclk_i(mclk_i), .fault_cmd_i(fault_cmd), .aux_cmd_i(aux_cmd),
    .pwm_i(pwm), .pwm_oe_n_i(oe_n), .fault_o(fault_w), .aux_o(aux_w), .gate_o(gate));
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Values read right after an edge are those the edge sampled.
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Toggles the capture pin every four cycles; starts just after an edge.
  task automatic toggle(input int n);
    repeat (n)
    begin
      aux_cmd <= ~aux_cmd;
      repeat (4) @(posedge mclk_i);
    end
  endtask : toggle
  // Watchdog: a hang is counted as a mismatch.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    end_of_test();
  end
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk("oe_reset", 32'(oe_n), 32'h3);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("row_err", 32'(err), 32'(rows[i].s));
      if (!rows[i].wr)
        chk("row_data", rd, rows[i].e);
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0301);
    // Each clearing mode: disable, release of the input, then flag clear.
    foreach (fctl[i])
    begin
      apb(1'b1, OFS_FCTL, fctl[i]);
      fault_cmd <= 4'h1;
      repeat (4) @(posedge mclk_i);
      // The high fault state lasts a whole period, which the waveform alone never does.
      n0 = 0;
      repeat (PER + 1)
      begin
        @(negedge mclk_i);
        n0 += gate[0];
      end
      chk("gate_a", n0, PER + 1);
      apb(1'b0, OFS_FAULT_STATUS, 32'h0);
      chk("flag_set", 32'(rd[0]), 32'h1);
      chk("dis_set", 32'(rd[12]), 32'h1);
      apb(1'b1, OFS_FAULT_STATUS, 32'h0000_0001);
      fault_cmd <= 4'h0;
      repeat (2 * (PER + 1) + 4) @(posedge mclk_i);
      apb(1'b0, OFS_FAULT_STATUS, 32'h0);
      chk("dis_after_drop", 32'(rd[12]), 32'(hold[i]));
      chk("flag_sticky", 32'(rd[0]), 32'h1);
      apb(1'b1, OFS_FAULT_STATUS, 32'h0000_0001);
      repeat (PER + 5) @(posedge mclk_i);
      apb(1'b0, OFS_FAULT_STATUS, 32'h0);
      chk("dis_after_clear", rd & 32'h0000_1001, 32'h0);
    end
    // Inverted level makes a low input the active fault.
    apb(1'b1, OFS_FCTL, 32'h0000_0001);
    apb(1'b0, OFS_FAULT_STATUS, 32'h0);
    chk("level_inv", 32'(rd[8]), 32'h1);
    // Full-cycle-only auto release leaves one low cycle; a half-cycle one would leave nine.
    apb(1'b1, OFS_FAULT_STATUS, 32'h0000_0010);
    apb(1'b1, OFS_FCTL, 32'h0000_0010);
    n0 = 0;
    do
    begin
      @(negedge mclk_i);
      n0++;
    end while (pwm[0] !== 1'b0 && n0 < 40);
    n1 = 0;
    while (pwm[0] === 1'b0 && n1 < 20)
    begin
      @(negedge mclk_i);
      n1++;
    end
    chk("full_only", n1, 1);
    apb(1'b1, OFS_FAULT_STATUS, 32'h0000_0001);
    // Mask plus force holds pin A low over whole periods.
    apb(1'b1, OFS_CTRL, 32'h0000_1303);
    @(posedge mclk_i);
    n0 = 0;
    repeat (2 * (PER + 1))
    begin
      @(negedge mclk_i);
      n0 += pwm[0];
    end
    chk("mask_low", n0, 0);
    // The channel B on and off compares give one trigger each per period.
    apb(1'b1, OFS_CTRL, 32'h0003_0301);
    @(posedge mclk_i);
    n0 = 0;
    n1 = 0;
    repeat (4 * (PER + 1))
    begin
      @(negedge mclk_i);
      n0 += trig[0];
      n1 += trig[1];
    end
    chk("trig_b_on", n0, 4);
    chk("trig_b_off", n1, 4);
    // Disabled output B goes tristate and the pull-up shows at the gate.
    apb(1'b1, OFS_CTRL, 32'h0000_0101);
    repeat (3) @(posedge mclk_i);
    chk("tristate_b", 32'({oe_n[1], gate[1]}), 32'h3);
    // One-shot capture on circuit one alone, from the prescaler pulse after four edges.
    apb(1'b1, OFS_CCTL, 32'h0005_048E);
    toggle(3);
    apb(1'b0, OFS_CSTS, 32'h0);
    chk("cap_early", rd, 32'h0);
    toggle(1);
    apb(1'b0, OFS_CSTS, 32'h0);
    chk("cap_presc", rd, 32'h2);
    chk("irq1", 32'(irq), 32'h2);
    apb(1'b1, OFS_CSTS, 32'h0000_0003);
    // Free-running ping-pong: two rising edges fill both circuits.
    apb(1'b1, OFS_CCTL, 32'h0007_00A3);
    // The arm strobe needs two edges to reach the circuits; an earlier edge is lost.
    repeat (2) @(posedge mclk_i);
    toggle(4);
    apb(1'b0, OFS_CSTS, 32'h0);
    chk("cap_pingpong", rd, 32'h3);
    chk("irq_both", 32'(irq), 32'h3);
    apb(1'b0, OFS_CV0, 32'h0);
    cv = rd;
    apb(1'b0, OFS_CV1, 32'h0);
    chk("cv_spacing", (rd - cv) & 32'h0000_000F, 32'h8);
    end_of_test();
  end
endmodule : test_pwmf_top
